/* File: design/oik_cfg.svh */
// Constants of the operator input and keying block
`ifndef OIK_CFG_SVH
`define OIK_CFG_SVH

// ************************************************************
// Clock and timing
// ************************************************************
`define OIK_CLK_HZ 10000000
`define OIK_TW 24
`define OIK_DEB_MS 5
`define OIK_DEB_CYC (`OIK_DEB_MS * (`OIK_CLK_HZ / 1000))
`define OIK_HOLD_MS 10
`define OIK_HOLD_CYC (`OIK_HOLD_MS * (`OIK_CLK_HZ / 1000))
`define OIK_DIT_MS 50
`define OIK_DIT_CYC (`OIK_DIT_MS * (`OIK_CLK_HZ / 1000))
`define OIK_DAH_UNITS 3
`define OIK_BAUD 9600
`define OIK_BIT_CYC (`OIK_CLK_HZ / `OIK_BAUD)

// ************************************************************
// Register offsets
// ************************************************************
`define OIK_A_CTRL 8'h00
`define OIK_A_STATUS 8'h04
`define OIK_A_MASK 8'h08
`define OIK_A_ENCODER 8'h0C
`define OIK_A_SERDATA 8'h10
`define OIK_A_DITLEN 8'h14
`define OIK_A_BEACON 8'h18

// ************************************************************
// Status bits, resets, button thresholds
// ************************************************************
`define OIK_ST_CLICK 0
`define OIK_ST_BUTTON 1
`define OIK_ST_BYTE 2
`define OIK_ST_SECOND 3
`define OIK_ST_AUTOPRAC 4
`define OIK_RST_PINS 5'h0F
`define OIK_RST_DEB 3'h3
`define OIK_RESP_OKAY 2'h0
`define OIK_RESP_SLVERR 2'h2
// Midpoints between 0, 3.76 V, 4.55 V and 5.00 V on a 5 V scale
`define OIK_ADC_NONE_MAX 10'h17F
`define OIK_ADC_LEFT_MAX 10'h353
`define OIK_ADC_RIGHT_MAX 10'h3D1

`endif

/* File: design/oik_pkg.sv */
// Types of the operator input and keying block
`default_nettype none
`include "oik_cfg.svh"
package oik_pkg;
   typedef logic [`OIK_TW-1:0] oik_cnt_t;
   typedef enum logic [1:0] {MODE_STRAIGHT, MODE_IAMBIC, MODE_BEACON}
      oik_mode_e;
   typedef enum logic [1:0] {KEY_IDLE, KEY_ELEM, KEY_GAP} oik_key_e;
   typedef enum logic [1:0] {SER_IDLE, SER_START, SER_DATA, SER_STOP}
      oik_ser_e;
   typedef enum logic {BSM_IDLE, BSM_WAIT} oik_bsm_e;
   typedef enum logic [1:0] {BTN_NONE, BTN_LEFT, BTN_RIGHT, BTN_CENTRE}
      oik_button_e;
   typedef struct packed {
      logic [4:0] sync1;
      logic [4:0] sync2;
      logic [2:0] deb;
      logic [2:0][`OIK_TW-1:0] dcnt;
      logic dit_prev;
      logic [1:0] enc_prev;
      logic [3:0] enc_acc;
      logic [7:0] enc_cnt;
      oik_bsm_e btn_st;
      oik_button_e btn_code;
      logic adc_req;
      oik_mode_e mode;
      logic prac;
      logic auto_prac;
      logic prac_o;
      oik_cnt_t dit_len;
      oik_key_e key_st;
      oik_cnt_t key_tmr;
      logic key_dah;
      logic key_last;
      logic beacon_req;
      logic beacon_dah;
      logic key_out;
      oik_cnt_t hold;
      logic rx_en;
      oik_ser_e ser_st;
      logic [15:0] ser_tmr;
      logic [2:0] ser_bits;
      logic [7:0] ser_sh;
      logic [7:0] ser_byte;
      logic [4:0] status;
      logic [4:0] mask;
      logic irq;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
   } oik_state_s;
endpackage
`default_nettype wire

/* File: design/oik_top.sv */
// Operator input decoding, keyer and transmit/receive sequencing
// Contract
// - Encoder decoded by state machine, bounce rejected
// - Paddle and button bounce filtered in logic
// - Button press seen as shared input going high
// - Converter level classifies left, right, centre, none
// - Straight mode copies key input to output
// - Keyer and beacon elements timed exactly
// - Receive enable held low ten ms after key-up
// - Receive enable high receiving, low transmitting
// - Transmit mute is inverse of receive enable
// - GPS serial at 9600 baud received in logic
// - Serial data forces practice mode, keying suppressed
//
// Added by the designer: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "oik_cfg.svh"
module oik_top #(
   parameter oik_pkg::oik_cnt_t DEB_CYC = oik_pkg::oik_cnt_t'(`OIK_DEB_CYC),
   parameter oik_pkg::oik_cnt_t HOLD_CYC =
      oik_pkg::oik_cnt_t'(`OIK_HOLD_CYC),
   parameter oik_pkg::oik_cnt_t DIT_CYC = oik_pkg::oik_cnt_t'(`OIK_DIT_CYC)
) (
   // Clock, reset, enable
   input wire logic clk_sys_in,
   input wire logic reset_in,
   input wire logic ce_in,
   // Pins
   input wire logic enc_a_in,
   input wire logic enc_b_in,
   input wire logic paddle_dit_n_in,
   input wire logic paddle_dah_n_in,
   input wire logic button_in,
   // Button converter
   output logic adc_start_out,
   input wire logic adc_valid_in,
   input wire logic [9:0] adc_data_in,
   // Keying and switching
   output logic key_out,
   output logic rx_enable_out,
   output logic tx_mute_out,
   output logic practice_out,
   output logic irq_out,
   // AXI4-Lite slave
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   // ************************************************************
   // State and bus handshakes
   // ************************************************************
   localparam logic [15:0] BIT_M1 = 16'(`OIK_BIT_CYC - 1);
   localparam logic [15:0] HALF_M1 = 16'(`OIK_BIT_CYC / 2 - 1);
   oik_pkg::oik_state_s st_r;
   oik_pkg::oik_state_s st_nxt;
   logic wr_go;
   logic rd_go;

   assign wr_go = ce_in & s_axi_awvalid & s_axi_wvalid & ~st_r.bvalid;
   assign rd_go = ce_in & s_axi_arvalid & ~st_r.rvalid;
   assign s_axi_awready = wr_go;
   assign s_axi_wready = wr_go;
   assign s_axi_arready = rd_go;

   function automatic logic [31:0] oik_merge(input logic [31:0] o,
         input logic [31:0] d, input logic [3:0] s);
      logic [31:0] m;
      m = o;
      for (int b = 0; b < 4; b++) begin
         if (s[b]) begin
            m[b*8 +: 8] = d[b*8 +: 8];
         end
      end
      return m;
   endfunction

   // ************************************************************
   // Next state
   // ************************************************************
   always_comb begin
      oik_pkg::oik_state_s n;
      logic [4:0] ev;
      logic [1:0] ab;
      logic [1:0] pb;
      logic [1:0] nb;
      logic dit_p;
      logic dah_p;
      logic start;
      logic nxt_dah;
      logic go;
      logic key_int;
      logic clr;
      logic [31:0] w;
      oik_pkg::oik_cnt_t dah_len;
      n = st_r;
      ev = 5'h00;
      ab = st_r.sync2[1:0];
      pb = {st_r.enc_prev[1], ^st_r.enc_prev};
      nb = {ab[1], ^ab};
      dit_p = ~st_r.deb[0];
      dah_p = ~st_r.deb[1];
      start = 1'b0;
      nxt_dah = 1'b0;
      go = 1'b0;
      key_int = 1'b0;
      clr = 1'b0;
      w = 32'h0000_0000;
      dah_len = oik_pkg::oik_cnt_t'(st_r.dit_len * `OIK_DAH_UNITS);
      n.sync1 = {button_in, paddle_dah_n_in, paddle_dit_n_in,
                 enc_b_in, enc_a_in};
      n.sync2 = st_r.sync1;
      // Level accepted only after it stays put for DEB_CYC cycles
      for (int i = 0; i < 3; i++) begin
         if (st_r.sync2[i+2] == st_r.deb[i]) begin
            n.dcnt[i] = '0;
         end else if (st_r.dcnt[i] == DEB_CYC - 1'b1) begin
            n.deb[i] = st_r.sync2[i+2];
            n.dcnt[i] = '0;
         end else begin
            n.dcnt[i] = st_r.dcnt[i] + 1'b1;
         end
      end
      // Quarter steps accumulate; a click counts only on a full cycle
      if (nb == pb + 2'h1) begin
         n.enc_acc = st_r.enc_acc + 4'h1;
      end else if (nb == pb - 2'h1) begin
         n.enc_acc = st_r.enc_acc - 4'h1;
      end
      n.enc_prev = ab;
      if (ab == 2'b11) begin
         if (n.enc_acc == 4'h4) begin
            n.enc_cnt = st_r.enc_cnt + 8'h01;
            ev[`OIK_ST_CLICK] = 1'b1;
         end else if (n.enc_acc == 4'hC) begin
            n.enc_cnt = st_r.enc_cnt - 8'h01;
            ev[`OIK_ST_CLICK] = 1'b1;
         end
         n.enc_acc = 4'h0;
      end
      // Buttons
      n.adc_req = 1'b0;
      unique case (st_r.btn_st)
         oik_pkg::BSM_IDLE: if (n.deb[2] & ~st_r.deb[2]) begin
            n.adc_req = 1'b1;
            n.btn_st = oik_pkg::BSM_WAIT;
         end
         oik_pkg::BSM_WAIT: if (adc_valid_in) begin
            if (adc_data_in <= `OIK_ADC_NONE_MAX) begin
               n.btn_code = oik_pkg::BTN_NONE;
            end else if (adc_data_in <= `OIK_ADC_LEFT_MAX) begin
               n.btn_code = oik_pkg::BTN_LEFT;
            end else if (adc_data_in <= `OIK_ADC_RIGHT_MAX) begin
               n.btn_code = oik_pkg::BTN_RIGHT;
            end else begin
               n.btn_code = oik_pkg::BTN_CENTRE;
            end
            ev[`OIK_ST_BUTTON] = 1'b1;
            n.btn_st = oik_pkg::BSM_IDLE;
         end
      endcase
      // Rising edge of the dit line marks the GPS second pulse
      n.dit_prev = st_r.sync2[2];
      ev[`OIK_ST_SECOND] = st_r.sync2[2] & ~st_r.dit_prev;
      // Serial receiver on the dah line, sampling mid-bit
      if (st_r.ser_tmr != 16'h0000) begin
         n.ser_tmr = st_r.ser_tmr - 16'h0001;
      end
      unique case (st_r.ser_st)
         oik_pkg::SER_IDLE: if (!st_r.sync2[3]) begin
            n.ser_st = oik_pkg::SER_START;
            n.ser_tmr = HALF_M1;
         end
         oik_pkg::SER_START: if (st_r.ser_tmr == 16'h0000) begin
            n.ser_st = st_r.sync2[3] ? oik_pkg::SER_IDLE : oik_pkg::SER_DATA;
            n.ser_tmr = BIT_M1;
            n.ser_bits = 3'h0;
         end
         oik_pkg::SER_DATA: if (st_r.ser_tmr == 16'h0000) begin
            n.ser_sh = {st_r.sync2[3], st_r.ser_sh[7:1]};
            n.ser_tmr = BIT_M1;
            n.ser_bits = st_r.ser_bits + 3'h1;
            if (st_r.ser_bits == 3'h7) begin
               n.ser_st = oik_pkg::SER_STOP;
            end
         end
         oik_pkg::SER_STOP: if (st_r.ser_tmr == 16'h0000) begin
            n.ser_st = oik_pkg::SER_IDLE;
            if (st_r.sync2[3]) begin
               n.ser_byte = st_r.ser_sh;
               ev[`OIK_ST_BYTE] = 1'b1;
               if (!st_r.prac && !st_r.auto_prac) begin
                  n.auto_prac = 1'b1;
                  ev[`OIK_ST_AUTOPRAC] = 1'b1;
               end
            end
         end
      endcase
      // Keyer: element, then one dit of key-up, then the next element
      if (st_r.mode == oik_pkg::MODE_IAMBIC && (dit_p | dah_p)) begin
         start = 1'b1;
         nxt_dah = (dit_p & dah_p) ? ~st_r.key_last : dah_p;
      end else if (st_r.mode == oik_pkg::MODE_BEACON && st_r.beacon_req) begin
         start = 1'b1;
         nxt_dah = st_r.beacon_dah;
      end
      unique case (st_r.key_st)
         oik_pkg::KEY_IDLE: go = start;
         oik_pkg::KEY_ELEM: if (st_r.key_tmr == '0) begin
            n.key_st = oik_pkg::KEY_GAP;
            n.key_tmr = st_r.dit_len - 1'b1;
            n.key_last = st_r.key_dah;
         end else begin
            n.key_tmr = st_r.key_tmr - 1'b1;
         end
         oik_pkg::KEY_GAP: if (st_r.key_tmr == '0) begin
            go = start;
            n.key_st = oik_pkg::KEY_IDLE;
         end else begin
            n.key_tmr = st_r.key_tmr - 1'b1;
         end
      endcase
      if (go) begin
         n.key_st = oik_pkg::KEY_ELEM;
         n.key_dah = nxt_dah;
         n.key_tmr = (nxt_dah ? dah_len : st_r.dit_len) - 1'b1;
         if (st_r.mode == oik_pkg::MODE_BEACON) begin
            n.beacon_req = 1'b0;
         end
      end
      if (st_r.mode == oik_pkg::MODE_STRAIGHT) begin
         key_int = dit_p;
      end else begin
         key_int = (n.key_st == oik_pkg::KEY_ELEM);
      end
      // Register bus
      if (st_r.bvalid && s_axi_bready) begin
         n.bvalid = 1'b0;
      end
      if (st_r.rvalid && s_axi_rready) begin
         n.rvalid = 1'b0;
      end
      if (wr_go) begin
         n.bvalid = 1'b1;
         n.bresp = `OIK_RESP_OKAY;
         unique case (s_axi_awaddr)
            `OIK_A_CTRL: begin
               w = oik_merge({29'h0, st_r.prac, st_r.mode}, s_axi_wdata,
                  s_axi_wstrb);
               if (w[1:0] != 2'h3) begin
                  n.mode = oik_pkg::oik_mode_e'(w[1:0]);
               end
               n.prac = w[2];
               // A serial byte that raises the flag in the same cycle keeps it set
               if (s_axi_wstrb[0] && !ev[`OIK_ST_AUTOPRAC]) begin
                  n.auto_prac = 1'b0;
               end
            end
            `OIK_A_MASK: begin
               w = oik_merge({27'h0, st_r.mask}, s_axi_wdata, s_axi_wstrb);
               n.mask = w[4:0];
            end
            `OIK_A_DITLEN: begin
               w = oik_merge({8'h00, st_r.dit_len}, s_axi_wdata, s_axi_wstrb);
               if (w[`OIK_TW-1:0] != '0) begin
                  n.dit_len = w[`OIK_TW-1:0];
               end
            end
            `OIK_A_BEACON: if (s_axi_wstrb[0] && !st_r.beacon_req) begin
               n.beacon_req = 1'b1;
               n.beacon_dah = s_axi_wdata[0];
            end
            `OIK_A_STATUS, `OIK_A_ENCODER, `OIK_A_SERDATA: ;
            default: n.bresp = `OIK_RESP_SLVERR;
         endcase
      end
      if (rd_go) begin
         n.rvalid = 1'b1;
         n.rresp = `OIK_RESP_OKAY;
         unique case (s_axi_araddr)
            `OIK_A_CTRL: n.rdata = {28'h0, st_r.auto_prac, st_r.prac,
               st_r.mode};
            `OIK_A_STATUS: begin
               n.rdata = {27'h0, st_r.status};
               clr = 1'b1;
            end
            `OIK_A_MASK: n.rdata = {27'h0, st_r.mask};
            `OIK_A_ENCODER: n.rdata = {22'h0, st_r.btn_code, st_r.enc_cnt};
            `OIK_A_SERDATA: n.rdata = {24'h0, st_r.ser_byte};
            `OIK_A_DITLEN: n.rdata = {8'h00, st_r.dit_len};
            `OIK_A_BEACON: n.rdata = {31'h0, st_r.beacon_req};
            default: begin
               n.rdata = 32'h0000_0000;
               n.rresp = `OIK_RESP_SLVERR;
            end
         endcase
      end
      // Events win over the clear by read
      n.status = (clr ? 5'h00 : st_r.status) | ev;
      n.irq = |(n.status & n.mask);
      // Keying, practice and transmit/receive sequencing
      n.prac_o = n.prac | n.auto_prac;
      n.key_out = key_int & ~n.prac_o;
      n.hold = n.key_out ? HOLD_CYC :
         (st_r.hold != '0 ? st_r.hold - 1'b1 : '0);
      n.rx_en = ~n.key_out & (st_r.hold == '0);
      st_nxt = n;
   end

   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         st_r <= '0;
         st_r.sync1 <= `OIK_RST_PINS;
         st_r.sync2 <= `OIK_RST_PINS;
         st_r.deb <= `OIK_RST_DEB;
         st_r.dit_prev <= 1'b1;
         st_r.enc_prev <= 2'b11;
         st_r.dit_len <= DIT_CYC;
         st_r.rx_en <= 1'b1;
      end else if (ce_in) begin
         st_r <= st_nxt;
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   assign adc_start_out = st_r.adc_req;
   assign key_out = st_r.key_out;
   assign rx_enable_out = st_r.rx_en;
   assign tx_mute_out = ~st_r.rx_en;
   assign practice_out = st_r.prac_o;
   assign irq_out = st_r.irq;
   assign s_axi_bvalid = st_r.bvalid;
   assign s_axi_bresp = st_r.bresp;
   assign s_axi_rvalid = st_r.rvalid;
   assign s_axi_rresp = st_r.rresp;
   assign s_axi_rdata = st_r.rdata;

   // ************************************************************
   // Checks
   // ************************************************************
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (reset_in || !ce_in);

   a_enc_at_detent: assert property ($changed(st_r.enc_cnt) |->
      $past(st_r.sync2[1:0]) == 2'b11 && $past(st_r.enc_acc) != 4'h0)
      else $error("encoder count moved away from detent");
   a_deb_settle: assert property ($changed(st_r.deb[0]) |->
      $past(st_r.dcnt[0]) == DEB_CYC - 1'b1)
      else $error("dit level taken before settle time");
   a_btn_start: assert property (adc_start_out |->
      $rose(st_r.deb[2]) ##1 !adc_start_out)
      else $error("converter start without a new press");
   a_btn_centre: assert property (st_r.btn_st == oik_pkg::BSM_WAIT
      && adc_valid_in && adc_data_in == 10'h3FF |=>
      st_r.btn_code == oik_pkg::BTN_CENTRE && st_r.status[1])
      else $error("full scale not classed as centre");
   a_key_straight: assert property (st_r.mode ==
      oik_pkg::MODE_STRAIGHT && !practice_out ##1 !practice_out |->
      key_out == !$past(st_r.deb[0]))
      else $error("straight key not copied");
   a_elem_len: assert property ($rose(st_r.key_st ==
      oik_pkg::KEY_ELEM) |-> st_r.key_tmr == (st_r.key_dah ?
      oik_pkg::oik_cnt_t'(st_r.dit_len * 3) : st_r.dit_len) - 1'b1)
      else $error("element length wrong");
   a_gap_len: assert property ($rose(st_r.key_st ==
      oik_pkg::KEY_GAP) |-> st_r.key_tmr == st_r.dit_len - 1'b1)
      else $error("gap is not one dit");
   a_hold_load: assert property ($fell(key_out) |->
      !rx_enable_out && st_r.hold == HOLD_CYC - 1'b1)
      else $error("receive hold not started at key-up");
   a_rx_restore: assert property (!key_out && !rx_enable_out
      && st_r.hold == '0 |=> rx_enable_out || key_out)
      else $error("receive not restored after hold");
   a_rx_keyed: assert property (key_out |-> !rx_enable_out)
      else $error("receive enabled while keyed");
   a_mute_inv: assert property (tx_mute_out != rx_enable_out)
      else $error("mute not inverse of receive enable");
   a_serial_prac: assert property (st_r.ser_st ==
      oik_pkg::SER_STOP && st_r.ser_tmr == '0 && st_r.sync2[3] |=>
      practice_out && !key_out[*2])
      else $error("serial data did not force practice");

   c_iambic_dah: cover property (st_r.mode == oik_pkg::MODE_IAMBIC
      && $rose(st_r.key_dah && key_out));
   c_auto_prac: cover property ($rose(st_r.auto_prac));
   c_btn_left: cover property (st_r.btn_code == oik_pkg::BTN_LEFT);
   c_hold_end: cover property ($rose(rx_enable_out));
endmodule
`default_nettype wire

/* File: tb/oik_partner.sv */
// Model of the operator controls, key paddle and GPS receiver
`timescale 1ns/1ps
`default_nettype none
`include "oik_cfg.svh"
module oik_partner (
   // Clock and pins
   input wire logic clk_sys_in,
   output logic enc_a_out = 1'b1,
   output logic enc_b_out = 1'b1,
   output logic dit_n_out = 1'b1,
   output logic dah_n_out = 1'b1,
   output logic button_out = 1'b0,
   // Button converter
   input wire logic adc_start_in,
   output logic adc_valid_out = 1'b0,
   output logic [9:0] adc_data_out = 10'h000
);
   logic [9:0] level = 10'h000;
   int busy = 0;
   // Answers four cycles after the request, junk on the data otherwise
   always @(posedge clk_sys_in) begin
      adc_valid_out <= busy == 1;
      adc_data_out <= busy == 1 ? level : ~adc_data_out;
      busy <= adc_start_in ? 4 : busy == 0 ? 0 : busy - 1;
   end
   // One detent; the first contact bounces once
   task automatic click(input bit up);
      logic [1:0] s [6];
      s = '{2'b10, 2'b11, 2'b10, 2'b00, 2'b01, 2'b11};
      foreach (s[i]) begin
         @(posedge clk_sys_in);
         {enc_b_out, enc_a_out} <= up ? s[i] : {s[i][0], s[i][1]};
         repeat (6) @(posedge clk_sys_in);
      end
   endtask
   task automatic paddles(input logic dit_n, input logic dah_n);
      @(posedge clk_sys_in);
      {dit_n_out, dah_n_out} <= {dit_n, dah_n};
   endtask
   task automatic press(input logic [9:0] lv);
      @(posedge clk_sys_in);
      {level, button_out} <= {lv, 1'b1};
      repeat (40) @(posedge clk_sys_in);
      button_out <= 1'b0;
      repeat (20) @(posedge clk_sys_in);
   endtask
   // Serial 8N1, LSB first, on the dah line while the paddle is idle
   task automatic send_byte(input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         @(posedge clk_sys_in);
         dah_n_out <= f[i];
         repeat (`OIK_BIT_CYC - 1) @(posedge clk_sys_in);
      end
   endtask
   // Rising edge after a low far longer than the debounce time
   task automatic second_pulse();
      paddles(1'b0, 1'b1);
      repeat (30) @(posedge clk_sys_in);
      paddles(1'b1, 1'b1);
   endtask
endmodule
`default_nettype wire

/* File: tb/tb.sv */
// Self-checking bench of the operator input and keying block
`timescale 1ns/1ps
`default_nettype none
`include "oik_cfg.svh"
module tb;
   localparam oik_pkg::oik_cnt_t HOLD = 24'h000014;
   localparam oik_pkg::oik_cnt_t DIT = 24'h00000A;
   logic clk_sys_in = 1'b0;
   logic reset_in = 1'b1;
   logic ce_in = 1'b1;
   logic enc_a_in, enc_b_in, paddle_dit_n_in, paddle_dah_n_in, button_in;
   logic adc_start_out, adc_valid_in, key_out, rx_enable_out, tx_mute_out;
   logic practice_out, irq_out, s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic s_axi_arready, s_axi_rvalid;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [9:0] adc_data_in;
   logic [9:0] lv [4] = '{10'h050, 10'h300, 10'h3A0, 10'h3FF};
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, obs, b;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, v;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   int fail_count = 0;
   int compares = 0;
   integer seed = 32'hfeaa;
   int n, d;
   assign obs = {practice_out, irq_out, s_axi_rvalid, s_axi_arready,
      s_axi_bvalid, s_axi_awready, rx_enable_out, key_out};
   always #50 clk_sys_in = ~clk_sys_in;
   oik_top #(.DEB_CYC(24'h000008), .HOLD_CYC(HOLD), .DIT_CYC(DIT)) oik_top_i (
      .clk_sys_in, .reset_in, .ce_in, .enc_a_in, .enc_b_in,
      .paddle_dit_n_in, .paddle_dah_n_in, .button_in, .adc_start_out,
      .adc_valid_in, .adc_data_in, .key_out, .rx_enable_out,
      .tx_mute_out, .practice_out, .irq_out, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   oik_partner oik_partner_i (.clk_sys_in, .enc_a_out(enc_a_in),
      .enc_b_out(enc_b_in), .dit_n_out(paddle_dit_n_in),
      .dah_n_out(paddle_dah_n_in), .button_out(button_in),
      .adc_start_in(adc_start_out), .adc_valid_out(adc_valid_in),
      .adc_data_out(adc_data_in));
   task automatic complete_run();
      if (fail_count == 0 && compares > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // Cycles for which one observed bit keeps level e
   task automatic span(input int k, input logic e);
      n = 0;
      while (obs[k] === e && n < 20000) begin
         @(negedge clk_sys_in);
         n++;
      end
   endtask
   task automatic wait_for(input int k, input logic e);
      @(negedge clk_sys_in);
      span(k, ~e);
      if (n >= 20000) begin
         check(32'h0, 32'h1);
         complete_run();
      end
   endtask
   // One write or one read; read data and response land in v and r
   task automatic bus(input bit w, input logic [7:0] a, input logic [31:0] x);
      @(posedge clk_sys_in);
      if (w) begin
         {s_axi_awaddr, s_axi_wdata} <= {a, x};
         {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      end else begin
         s_axi_araddr <= a;
         {s_axi_arvalid, s_axi_rready} <= 2'h3;
      end
      wait_for(w ? 2 : 4, 1'b1);
      @(posedge clk_sys_in);
      {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} <= 3'h0;
      wait_for(w ? 3 : 5, 1'b1);
      v = w ? 32'h0 : s_axi_rdata;
      r = w ? s_axi_bresp : s_axi_rresp;
      @(posedge clk_sys_in);
      {s_axi_bready, s_axi_rready} <= 2'h0;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      check(v, e);
   endtask
   function automatic int code(input int x);
      return x <= `OIK_ADC_NONE_MAX ? 0 : x <= `OIK_ADC_LEFT_MAX ? 1 :
         x <= `OIK_ADC_RIGHT_MAX ? 2 : 3;
   endfunction
   // Practice must hold the transmitter off
   always @(negedge clk_sys_in) begin
      if (practice_out === 1'b1)
         check(key_out, 1'b0);
   end
   initial begin
      repeat (12) @(posedge clk_sys_in);
      reset_in <= 1'b0;
      check({rx_enable_out, tx_mute_out}, 2'b10);
      for (int i = 0; i < 8; i++) begin
         bus(1'b0, 8'(4 * i), 32'h0);
         check(v, i == 5 ? 32'(DIT) : 32'h0);
         check(r, i == 7 ? `OIK_RESP_SLVERR : `OIK_RESP_OKAY);
      end
      bus(1'b1, `OIK_A_MASK, 32'h1);
      oik_partner_i.click(1'b1);
      oik_partner_i.click(1'b1);
      oik_partner_i.click(1'b0);
      rdc(`OIK_A_ENCODER, 32'h1);
      check(irq_out, 1'b1);
      rdc(`OIK_A_STATUS, 32'h1);
      wait_for(6, 1'b0);
      oik_partner_i.paddles(1'b0, 1'b1);
      repeat (3) @(posedge clk_sys_in);
      oik_partner_i.paddles(1'b1, 1'b1);
      repeat (20) @(negedge clk_sys_in);
      check(key_out, 1'b0);
      oik_partner_i.paddles(1'b0, 1'b1);
      wait_for(0, 1'b1);
      check({rx_enable_out, tx_mute_out}, 2'b01);
      oik_partner_i.paddles(1'b1, 1'b1);
      wait_for(0, 1'b0);
      span(1, 1'b0);
      check(n, HOLD);
      check(tx_mute_out, 1'b0);
      d = 4 + ($random(seed) & 7);
      bus(1'b1, `OIK_A_DITLEN, d);
      rdc(`OIK_A_DITLEN, d);
      bus(1'b1, `OIK_A_CTRL, 32'h1);
      oik_partner_i.paddles(1'b0, 1'b0);
      wait_for(0, 1'b1);
      // Both paddles from idle: the keyer opens with a dah
      span(0, 1'b1);
      check(n, 3 * d);
      span(0, 1'b0);
      check(n, d);
      span(0, 1'b1);
      check(n, d);
      oik_partner_i.paddles(1'b1, 1'b1);
      wait_for(1, 1'b1);
      bus(1'b1, `OIK_A_CTRL, 32'h2);
      bus(1'b1, `OIK_A_BEACON, 32'h1);
      wait_for(0, 1'b1);
      span(0, 1'b1);
      check(n, 3 * d);
      wait_for(1, 1'b1);
      for (int i = 0; i < 4; i++) begin
         oik_partner_i.press(lv[i]);
         bus(1'b0, `OIK_A_ENCODER, 32'h0);
         check(v[9:8], code(lv[i]));
         bus(1'b0, `OIK_A_STATUS, 32'h0);
         check(v[1], 1'b1);
      end
      bus(1'b1, `OIK_A_CTRL, 32'h0);
      b = 8'($random(seed));
      oik_partner_i.send_byte(b);
      rdc(`OIK_A_SERDATA, b);
      check(practice_out, 1'b1);
      oik_partner_i.second_pulse();
      repeat (20) @(negedge clk_sys_in);
      check(irq_out, 1'b0);
      rdc(`OIK_A_STATUS, 32'h1C);
      complete_run();
   end
endmodule
`default_nettype wire
